// ==== hdl/ring_signal_validator.sv ====
// ring validation qualifier with its configuration registers on avalon-mm
// assumes ring_event_i is a one-cycle pulse synchronous to core_clk_i
//
// What this block does
// - delay code picks validation-to-indication delay
// - ring over after timeout without crossing
// - valid only after in-range confirmation time
// - enable bit clear turns qualification off
// - each event while enabled reloads interval timer, counts down
// - event after timer expiry: too low, invalidate
// - min spacing is assertion minus max
// - remaining time above max: too high, invalidate
// - delay low bits and max in preceding byte
`include "ring_signal_validator_defs.svh"

module ring_signal_validator #(
  parameter int TICK_CYCLES = `RSV_CLK_KHZ * `RSV_TICK_MS
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // line-side detector
  input  wire logic        ring_event_i,
  // ring indication
  output logic             ring_valid_o
);
  import ring_signal_validator_pkg::*;

  // a zero-cycle tick has no meaning; refuse it at elaboration, not at run time
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least 1");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [7:0]   cfg_a_q;
  logic [7:0]   cfg_b_q;
  logic [7:0]   cfg_c_q;
  logic         wait_q;
  logic [TW-1:0] tick_cnt_q;
  logic         tick_q;
  ring_state_t  state_q;
  ring_state_t  state_d;
  logic [5:0]   ivl_q;
  logic [9:0]   phase_q;
  logic [9:0]   to_q;
  logic [9:0]   conf_lim;
  logic [9:0]   dly_lim;
  logic [9:0]   to_lim;
  logic [2:0]   dly_code;
  logic         enable;
  logic         bad_evt;
  logic [5:0]   idx;
  logic         acc;
  logic [7:0]   rd_byte;

  assign enable   = cfg_b_q[`RSV_B_EN];
  // delay code split over two bytes
  assign dly_code = {cfg_a_q[`RSV_A_DLY2], cfg_c_q[`RSV_C_DLY_HI:`RSV_C_DLY_LO]};
  assign dly_lim  = 10'(dly_code) * `RSV_DLY_STEP;
  // code zero would end a ring at once; software keeps it away
  assign to_lim   = 10'(cfg_a_q[`RSV_A_TO_HI:`RSV_A_TO_LO]) * `RSV_TO_STEP;
  assign idx      = address_i[7:2];
  assign acc      = (read_i || write_i) && !wait_q;

  // confirmation time table
  always_comb begin
    case (cfg_a_q[`RSV_A_CONF_HI:`RSV_A_CONF_LO])
      3'h0:    conf_lim = `RSV_CONF_0;
      3'h1:    conf_lim = `RSV_CONF_1;
      3'h2:    conf_lim = `RSV_CONF_2;
      3'h3:    conf_lim = `RSV_CONF_3;
      3'h4:    conf_lim = `RSV_CONF_4;
      3'h5:    conf_lim = `RSV_CONF_5;
      3'h6:    conf_lim = `RSV_CONF_6;
      default: conf_lim = `RSV_CONF_7;
    endcase
  end

  // an event fails if the timer ran out (too low) or too much remains (too high);
  // the window left is assertion minus max, in 2 ms ticks
  assign bad_evt = (ivl_q == 6'h00) ||
                   (ivl_q > cfg_c_q[`RSV_C_MAX_HI:`RSV_C_MAX_LO]);

  // bus handshake: one wait cycle, then the access completes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else if (read_i || write_i) begin
      wait_q <= !wait_q;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign waitrequest_o = wait_q;

  // register writes take effect at the completing edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_a_q <= `RSV_RST_CFG_A;
      cfg_b_q <= `RSV_RST_CFG_B;
      cfg_c_q <= `RSV_RST_CFG_C;
    end else if (acc && write_i) begin
      case (8'(idx))
        `RSV_IDX_CFG_A: cfg_a_q <= writedata_i[7:0];
        `RSV_IDX_CFG_B: cfg_b_q <= writedata_i[7:0];
        `RSV_IDX_CFG_C: cfg_c_q <= writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (8'(idx))
      `RSV_IDX_CFG_A:  rd_byte = cfg_a_q;
      `RSV_IDX_CFG_B:  rd_byte = cfg_b_q;
      `RSV_IDX_CFG_C:  rd_byte = cfg_c_q;
      `RSV_IDX_STATUS: rd_byte = {5'h00, state_q == ST_DELAY,
                                  state_q == ST_QUALIFY, ring_valid_o};
      default:         rd_byte = 8'h00;
    endcase
  end

  // read data loaded in the wait cycle so it stands at the completing edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && wait_q) begin
      readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // free-running 2 ms tick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // phase sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (ring_event_i) state_d = ST_QUALIFY;
      end
      ST_QUALIFY: begin
        if (phase_q >= conf_lim) state_d = ST_DELAY;
      end
      ST_DELAY: begin
        if (phase_q >= dly_lim) state_d = ST_VALID;
      end
      ST_VALID: ;
      default: state_d = ST_IDLE;
    endcase
    // a bad interval restarts qualification from this event
    if (state_q != ST_IDLE && ring_event_i && bad_evt) state_d = ST_QUALIFY;
    // silence past the timeout ends the ring
    if (state_q != ST_IDLE && to_q >= to_lim) state_d = ST_IDLE;
    if (!enable) state_d = ST_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // interval timer: reload on each event while enabled, count down per tick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ivl_q <= 6'h00;
    end else if (ring_event_i && enable) begin
      ivl_q <= cfg_b_q[`RSV_B_AST_HI:`RSV_B_AST_LO];
    end else if (tick_q && ivl_q != 6'h00) begin
      ivl_q <= ivl_q - 1'b1;
    end
  end

  // confirm/delay counter, cleared on each phase change
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 10'h000;
    end else if (state_d != state_q || (ring_event_i && bad_evt)) begin
      phase_q <= 10'h000;
    end else if (tick_q && phase_q != 10'h3ff) begin
      phase_q <= phase_q + 1'b1;
    end
  end

  // time since the last crossing; saturates rather than wraps
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_q <= 10'h000;
    end else if (ring_event_i || state_q == ST_IDLE) begin
      to_q <= 10'h000;
    end else if (tick_q && to_q != 10'h3ff) begin
      to_q <= to_q + 1'b1;
    end
  end

  // indication follows the validated phase
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ring_valid_o <= 1'b0;
    end else begin
      ring_valid_o <= (state_d == ST_VALID);
    end
  end
endmodule : ring_signal_validator

// ==== shared/ring_signal_validator_defs.svh ====
// register map, field positions, reset values and timing figures of the ring validator
// assumes inclusion by the package and the validator module only
`ifndef RING_SIGNAL_VALIDATOR_DEFS_SVH
`define RING_SIGNAL_VALIDATOR_DEFS_SVH

// register indices; byte address is four times the index
`define RSV_IDX_CFG_C        8'h16
`define RSV_IDX_CFG_A        8'h17
`define RSV_IDX_CFG_B        8'h18
`define RSV_IDX_STATUS       8'h19

// reset values
`define RSV_RST_CFG_C        8'h96
`define RSV_RST_CFG_A        8'h2d
`define RSV_RST_CFG_B        8'h19

// config c fields: delay code low bits, max interval
`define RSV_C_DLY_HI         7
`define RSV_C_DLY_LO         6
`define RSV_C_MAX_HI         5
`define RSV_C_MAX_LO         0
// config a fields: delay code high bit, end timeout, confirm time
`define RSV_A_DLY2           7
`define RSV_A_TO_HI          6
`define RSV_A_TO_LO          3
`define RSV_A_CONF_HI        2
`define RSV_A_CONF_LO        0
// config b fields: qualify enable, assertion time
`define RSV_B_EN             7
`define RSV_B_AST_HI         5
`define RSV_B_AST_LO         0
// status bits
`define RSV_S_VALID          0
`define RSV_S_QUAL           1
`define RSV_S_DELAY          2

// base tick: 2 ms, the unit of every timer below
`define RSV_CLK_KHZ          25000
`define RSV_TICK_MS          2
// delay step 256 ms, timeout step 128 ms, in ticks
`define RSV_DLY_STEP         10'd128
`define RSV_TO_STEP          10'd64
// confirmation times 100..1024 ms, in ticks
`define RSV_CONF_0           10'd50
`define RSV_CONF_1           10'd75
`define RSV_CONF_2           10'd100
`define RSV_CONF_3           10'd128
`define RSV_CONF_4           10'd192
`define RSV_CONF_5           10'd256
`define RSV_CONF_6           10'd320
`define RSV_CONF_7           10'd512

`endif

// ==== shared/ring_signal_validator_pkg.sv ====
// types used by the ring validator alone; its bench does not import them
// assumes the defs header sits beside it on the include path
package ring_signal_validator_pkg;
  `include "ring_signal_validator_defs.svh"

  // qualification phases
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_QUALIFY,
    ST_DELAY,
    ST_VALID
  } ring_state_t;
endpackage : ring_signal_validator_pkg

// ==== sim/ring_line_model.sv ====
// line-side detector stand-in: one-cycle threshold events at a set spacing
// assumes the bench moves run_i and gap_i just after a rising edge
module ring_line_model (
  input  wire logic        core_clk_i, rst_n_i, run_i,
  input  wire logic [15:0] gap_i,
  output logic             ring_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  // a shorter spacing acts at once; first event as run_i rises
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= '0;
    else cnt_q <= (!run_i || cnt_q >= gap_i - 16'd1) ? '0 : cnt_q + 16'd1;
  end
  assign ring_event_o = run_i && cnt_q == '0;
endmodule : ring_line_model

// ==== sim/ring_signal_validator_test.sv ====
// self-checking bench for the ring validator over its avalon-mm port
// assumes a 4-cycle tick so that each ring figure stays short
module ring_signal_validator_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0, run = 1'b0;
  logic        waitrequest_o, ring_event_i, ring_valid_o;
  logic [7:0]  address_i = '0;
  logic [15:0] gap = 16'd40;
  logic [31:0] writedata_i = '0, readdata_o, rd;
  int          error_cnt = 0, checked = 0, n, e, dl;
  int          conf [8] = '{50, 75, 100, 128, 192, 256, 320, 512};
  int          rv [4] = '{'h96, 'h2d, 'h19, 0};
  ring_signal_validator #(.TICK_CYCLES(T)) dut (.core_clk_i, .rst_n_i, .address_i, .read_i,
    .write_i, .writedata_i, .readdata_o, .waitrequest_o, .ring_event_i, .ring_valid_o);
  ring_line_model line (.core_clk_i, .rst_n_i, .run_i(run), .gap_i(gap),
    .ring_event_o(ring_event_i));
  // 25 mhz core clock
  initial forever #20 core_clk_i = ~core_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic give_up;
    error_cnt++;
    print_verdict();
  endtask : give_up
  // one access, held until waitrequest is seen low; idle edge after it
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    {write_i, read_i, address_i, writedata_i} <= {wr, !wr, a, 2'b00, 24'h0, d};
    n = 0;
    do @(posedge core_clk_i); while (waitrequest_o !== 1'b0 && ++n < 50);
    // read data taken at the completing edge itself
    rd = readdata_o;
    {write_i, read_i} <= 2'b00;
    @(posedge core_clk_i);
    if (n >= 50) give_up();
  endtask : bus
  // counts edges until the ring level reads v, bounded by lim
  task automatic wait_ring(input logic v, input int lim);
    for (n = 0; ring_valid_o !== v && n < lim; n++) @(posedge core_clk_i);
    if (n >= lim) give_up();
  endtask : wait_ring
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    // reset values, then an unmapped place that keeps nothing
    foreach (rv[k]) begin
      bus(1'b0, 6'(6'h16 + k), 8'h0);
      check(rd, rv[k]);
    end
    bus(1'b1, 6'h20, 8'h5a);
    bus(1'b0, 6'h20, 8'h0);
    check(rd, 32'h0);
    run <= 1'b1;
    repeat (600) @(posedge core_clk_i);
    check(ring_valid_o, 1'b0);
    run <= 1'b0;
    $display("test registers done");
    // every confirm code, the listed delay codes, odd timeout codes 1 to 15
    for (int i = 0; i < 8; i++) begin
      dl = (i % 4 == 3) ? 7 : i % 4;
      bus(1'b1, 6'h16, {dl[1:0], 6'h16});
      bus(1'b1, 6'h17, {dl[2], 4'(2 * i + 1), 3'(i)});
      bus(1'b1, 6'h18, 8'h99);
      run <= 1'b1;
      wait_ring(1'b1, 8000);
      e = (conf[i] + dl * 128) * T;
      check(n >= e - 2 * T && n <= e + 3 * T, 1'b1);
      run <= 1'b0;
      wait_ring(1'b0, 5000);
      e = (2 * i + 1) * 64 * T;
      check(n >= e - 48 && n <= e + 12, 1'b1);
    end
    $display("test timing done");
    // a live ring broken by fast events, slow events, then by disable
    for (int j = 0; j < 3; j++) begin
      bus(1'b1, 6'h18, 8'h99);
      gap <= 16'd40;
      run <= 1'b1;
      wait_ring(1'b1, 8000);
      bus(1'b0, 6'h19, 8'h0);
      check(rd, 32'h1);
      if (j == 2) bus(1'b1, 6'h18, 8'h19);
      else gap <= (j == 1) ? 16'd120 : 16'd4;
      wait_ring(1'b0, 200);
      check(ring_valid_o, 1'b0);
      // a failed ring keeps qualifying; a disabled one sits idle
      bus(1'b0, 6'h19, 8'h0);
      check(rd, (j == 2) ? 32'h0 : 32'h2);
      run <= 1'b0;
    end
    $display("test faults done");
    print_verdict();
  end
endmodule : ring_signal_validator_test

// ==== sim/rsv_checker_asserts.sv ====
// checker for the ring validator: bus answer, config shadow, ring level
// assumes binding to the top module with the same TICK_CYCLES
module rsv_checker #(parameter int TICK_CYCLES = 4) (
  // bus and ring signals, all watched only
  input wire logic        core_clk_i, rst_n_i, read_i, write_i, waitrequest_o,
  input wire logic        ring_event_i, ring_valid_o,
  input wire logic [7:0]  address_i,
  input wire logic [31:0] writedata_i, readdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  sh_q [3];
  logic [15:0] gap_q, on_q;
  logic [1:0]  sel;
  logic        cfg;
  assign sel = address_i[3:2] + 2'd2;
  assign cfg = address_i[7:2] >= 6'h16 && address_i[7:2] <= 6'h18;
  // config shadow, cycles since the last event and since enable (saturating)
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= '{8'h96, 8'h2d, 8'h19};
      gap_q <= '0;
      on_q <= '0;
    end else begin
      if (write_i && !waitrequest_o && cfg) sh_q[sel] <= writedata_i[7:0];
      gap_q <= ring_event_i ? '0 : gap_q + 16'(gap_q != '1);
      on_q <= sh_q[2][7] ? on_q + 16'(on_q != '1) : '0;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_wait_bound: assert property ((read_i || write_i) && waitrequest_o
    |-> ##[1:2] !waitrequest_o) else $error("bus answer late");
  a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o) else $error("wait stuck low");
  a_read_data: assert property (read_i && !waitrequest_o && address_i[7:2] != 6'h19
    |-> readdata_o == (cfg ? {24'h0, sh_q[sel]} : 32'h0)) else $error("bad read data");
  a_off_quiet: assert property (!sh_q[2][7] [*3] |-> !ring_valid_o)
    else $error("ring shown while off");
  a_timeout_end: assert property (gap_q > sh_q[1][6:3] * 64 * TICK_CYCLES
    + 2 * TICK_CYCLES + 3 |-> !ring_valid_o) else $error("ring kept past timeout");
  // margins of a tick on the slow side and two ticks on the fast side absorb the free-running tick phase
  a_slow_drop: assert property (ring_valid_o && ring_event_i
    && gap_q > (sh_q[2][5:0] + 1) * TICK_CYCLES |-> ##2 !ring_valid_o) else $error("slow kept");
  a_fast_drop: assert property (ring_valid_o && ring_event_i
    && gap_q + (sh_q[0][5:0] + 2) * TICK_CYCLES < sh_q[2][5:0] * TICK_CYCLES
    |-> ##2 !ring_valid_o) else $error("fast kept");
  a_rise_late: assert property ($rose(ring_valid_o) |-> on_q >= 49 * TICK_CYCLES)
    else $error("ring shown too soon");
  c_up: cover property ($rose(ring_valid_o));
  c_down: cover property ($fell(ring_valid_o));
  c_read: cover property (read_i && !waitrequest_o);
endmodule : rsv_checker

bind ring_signal_validator rsv_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_i (
  .core_clk_i, .rst_n_i, .read_i, .write_i, .waitrequest_o, .ring_event_i,
  .ring_valid_o, .address_i, .writedata_i, .readdata_o);
